// ### pkg/pdt_defines.svh
// Purpose: Addresses, field positions and reset values of the PWM dead-time block
// Assumes: Byte addresses decoded from haddr[7:0]
// Notes: Definitions only
`ifndef PDT_DEFINES_SVH
`define PDT_DEFINES_SVH

// Register byte offsets
`define PDT_ADDR_CTRL 8'h00
`define PDT_ADDR_DUTY 8'h04
`define PDT_ADDR_DTIME 8'h08
`define PDT_ADDR_ALTDT 8'h0c
`define PDT_ADDR_TBCTL 8'h10
`define PDT_ADDR_PERIOD 8'h14
`define PDT_ADDR_TRIGCMP 8'h18
`define PDT_ADDR_STATUS 8'h1c

// Field positions
`define PDT_CTRL_MODE_MSB 1
`define PDT_CTRL_MODE_LSB 0
`define PDT_CTRL_INDEP_BIT 2
`define PDT_TB_EN_BIT 15
`define PDT_TB_PS_MSB 3
`define PDT_TB_PS_LSB 0
`define PDT_ST_HIGH_BIT 0
`define PDT_ST_LOW_BIT 1
`define PDT_ST_ACTIVE_BIT 2
`define PDT_ST_TRIG_BIT 3
`define PDT_ST_CNT_MSB 28
`define PDT_ST_CNT_LSB 16

// Duty limits
`define PDT_DUTY_MIN 16'h0008
`define PDT_DUTY_FULL 16'hffff
`define PDT_DUTY_ZERO 16'h0000

// Reset values and counter step constants
`define PDT_DUTY_RST 16'h0000
`define PDT_DT_RST 12'h000
`define PDT_PERIOD_RST 13'h1fff
`define PDT_TRIGCMP_RST 13'h0000
`define PDT_PS_RST 4'h0
`define PDT_CNT_RST 13'h0000
`define PDT_DT_CNT_ZERO 12'h000
`define PDT_DT_CNT_ONE 12'h001
`define PDT_CNT_ONE 13'h0001
`define PDT_PS_ONE 4'h1

`endif

// ### pkg/pdt_pkg.sv
// Purpose: Types shared by the PWM dead-time block
// Assumes: Nothing
// Notes: Mode codes follow the two-bit dead-time mode field
package pdt_pkg;

  typedef enum logic [1:0] {
    DT_POSITIVE,
    DT_NEGATIVE,
    DT_OFF,
    DT_OFF_ALT
  } pdt_dt_mode_type;

  typedef enum logic {
    OUT_COMPLEMENTARY,
    OUT_INDEPENDENT
  } pdt_out_mode_type;

  // Low bit goes to fine edge logic, only the rest is counted
  function automatic logic [11:0] pdt_coarse(input logic [11:0] dt, input logic on);
    pdt_coarse = on ? {1'b0, dt[11:1]} : 12'h000;
  endfunction

endpackage

// ### rtl/pdt_dead_time_unit.sv
// Purpose: One dead-time unit: edge detector and 12-bit down counter
// Assumes: src comes from logic on hclk
// Notes: Zero count means pass-through
`include "pdt_defines.svh"
module pdt_dead_time_unit (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Control
  input wire logic negative,
  input wire logic [11:0] coarse,
  // Signal
  input wire logic src,
  output logic dst
);
  logic src_ff;
  logic [11:0] cnt_ff;
  logic edge_hit;
  logic busy;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      src_ff <= 1'b0;
    end else begin
      src_ff <= src;
    end
  end

  // Positive mode watches turn-on, negative mode watches turn-off
  assign edge_hit = negative ? (src_ff & ~src) : (src & ~src_ff);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_ff <= `PDT_DT_CNT_ZERO;
    end else if (edge_hit && coarse != `PDT_DT_CNT_ZERO) begin
      cnt_ff <= coarse - `PDT_DT_CNT_ONE;
    end else if (cnt_ff != `PDT_DT_CNT_ZERO) begin
      cnt_ff <= cnt_ff - `PDT_DT_CNT_ONE;
    end
  end

  assign busy = (edge_hit && coarse != `PDT_DT_CNT_ZERO) || cnt_ff != `PDT_DT_CNT_ZERO;
  assign dst = negative ? (src | busy) : (src & ~busy); // see R9

endmodule

// ### rtl/pdt_event_trigger.sv
// Purpose: Special event trigger with postscaler
// Assumes: tick marks each primary counter step
// Notes: A compare write in the same cycle as a hit wins
`include "pdt_defines.svh"
module pdt_event_trigger (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Time base
  input wire logic tick,
  input wire logic [12:0] counter,
  // Control
  input wire logic [12:0] compare,
  input wire logic [3:0] postscale,
  input wire logic cmp_write,
  // Trigger
  output logic trigger
);
  logic [3:0] post_ff;
  logic hit;

  assign hit = tick && counter == compare;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      post_ff <= `PDT_PS_RST;
      trigger <= 1'b0;
    end else if (cmp_write) begin
      post_ff <= `PDT_PS_RST;
      trigger <= 1'b0;
    // Lowering the ratio mid-count fires at the next hit instead of wrapping
    end else if (hit && post_ff >= postscale) begin
      post_ff <= `PDT_PS_RST;
      trigger <= 1'b1;
    end else if (hit) begin
      post_ff <= post_ff + `PDT_PS_ONE;
      trigger <= 1'b0;
    end else begin
      trigger <= 1'b0;
    end
  end

endmodule

// ### rtl/pdt_top.sv
// Purpose: PWM generator with dead time and special event trigger, AHB-Lite registers
// Assumes: hclk is the fast PWM clock, zero-wait single word transfers
// Notes: Outputs pass one register after the dead-time units
//
// How it works
// R1: Pulse only for duty at least 0x0008
// R2: Software keeps duty within 0x0008..0xFFEF
// R3: Duty 0x0000 stays low, 0xFFFF stays high
// R4: Output waits dead time after partner off
// R5: Dead time in every output mode
// R6: Negative dead time overlaps both outputs
// R7: Mode field disables dead time; no zero
// R8: Edge detectors feed 12-bit down counters
// R9: Turn-on delayed until counter hits zero
// R10: Alternate dead time for complementary output
// R11: 12-bit unsigned value, fast clock counting
// R12: Dead time LSB goes to fine logic
// R13: Software keeps duty over three dead times
// R14: Software keeps off time over three dead times
// R15: Trigger fires on primary counter compare match
// R16: Compare register plus four-bit postscale field
// R17: Trigger pulses always produced, no enable
// R18: Postscaler 1:1..1:16, cleared by compare write
// R19: Active while counter within duty upper bits
// R20: Complementary low is inverse of active
// R21: Primary delays high rise, alternate low rise
`include "pdt_defines.svh"
module pdt_top (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // Power stage outputs
  output logic high_side_output,
  output logic low_side_output,
  // Fine edge adjust
  output logic [2:0] duty_fine,
  output logic dt_fine_high,
  output logic dt_fine_low,
  // ADC trigger
  output logic special_event_trigger
);
  // Registers
  logic [1:0] dead_time_mode_field_ff;
  logic out_indep_ff;
  logic [15:0] duty_ff;
  logic [11:0] dead_time_ff;
  logic [11:0] alternate_dead_time_value_ff;
  logic tb_en_ff;
  logic [3:0] trigger_postscale_field_ff;
  logic [12:0] period_ff;
  logic [12:0] trigger_compare_value_ff;
  logic [12:0] primary_counter_ff;

  // Bus state
  logic wr_pend_ff;
  logic [7:0] wr_addr_ff;
  logic addr_valid;
  logic cmp_write;

  // Datapath
  logic active;
  logic low_src;
  logic dt_on;
  logic dt_neg;
  logic [11:0] coarse_high;
  logic [11:0] coarse_low;
  logic high_dt;
  logic low_dt;

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  // hsize is accepted but only whole-word transfers are expected
  assign addr_valid = hsel && htrans[1] && hready;

  // Address phase capture for writes
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_ff <= 1'b0;
      wr_addr_ff <= `PDT_ADDR_CTRL;
    end else if (hready) begin
      wr_pend_ff <= addr_valid && hwrite;
      wr_addr_ff <= haddr[7:0];
    end
  end

  // Read data registered at the end of the address phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= '0;
    end else if (addr_valid && !hwrite) begin
      case (haddr[7:0])
        `PDT_ADDR_CTRL: begin
          hrdata <= {29'h0, out_indep_ff, dead_time_mode_field_ff};
        end
        `PDT_ADDR_DUTY: begin
          hrdata <= {16'h0, duty_ff};
        end
        `PDT_ADDR_DTIME: begin
          hrdata <= {20'h0, dead_time_ff};
        end
        `PDT_ADDR_ALTDT: begin
          hrdata <= {20'h0, alternate_dead_time_value_ff};
        end
        `PDT_ADDR_TBCTL: begin
          hrdata <= {16'h0, tb_en_ff, 11'h0, trigger_postscale_field_ff};
        end
        `PDT_ADDR_PERIOD: begin
          hrdata <= {19'h0, period_ff};
        end
        `PDT_ADDR_TRIGCMP: begin
          hrdata <= {19'h0, trigger_compare_value_ff};
        end
        `PDT_ADDR_STATUS: begin
          hrdata <= {3'h0, primary_counter_ff, 12'h0, special_event_trigger,
                     active, low_side_output, high_side_output};
        end
        default: begin
          hrdata <= '0;
        end
      endcase
    end
  end

  // Generator control
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dead_time_mode_field_ff <= pdt_pkg::DT_POSITIVE;
      out_indep_ff <= pdt_pkg::OUT_COMPLEMENTARY;
    end else if (wr_pend_ff && wr_addr_ff == `PDT_ADDR_CTRL) begin
      dead_time_mode_field_ff <= hwdata[`PDT_CTRL_MODE_MSB:`PDT_CTRL_MODE_LSB];
      out_indep_ff <= hwdata[`PDT_CTRL_INDEP_BIT];
    end
  end

  // Duty value, taken unclamped
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      duty_ff <= `PDT_DUTY_RST;
    end else if (wr_pend_ff && wr_addr_ff == `PDT_ADDR_DUTY) begin
      duty_ff <= hwdata[15:0]; // see R2
    end
  end

  // Dead-time values, 12-bit unsigned
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dead_time_ff <= `PDT_DT_RST;
      alternate_dead_time_value_ff <= `PDT_DT_RST;
    end else if (wr_pend_ff && wr_addr_ff == `PDT_ADDR_DTIME) begin
      dead_time_ff <= hwdata[11:0]; // see R11
    end else if (wr_pend_ff && wr_addr_ff == `PDT_ADDR_ALTDT) begin
      alternate_dead_time_value_ff <= hwdata[11:0]; // see R10
    end
  end

  // Time-base control, period and trigger compare
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tb_en_ff <= 1'b0;
      trigger_postscale_field_ff <= `PDT_PS_RST;
      period_ff <= `PDT_PERIOD_RST;
      trigger_compare_value_ff <= `PDT_TRIGCMP_RST;
    end else if (wr_pend_ff && wr_addr_ff == `PDT_ADDR_TBCTL) begin
      tb_en_ff <= hwdata[`PDT_TB_EN_BIT];
      trigger_postscale_field_ff <= hwdata[`PDT_TB_PS_MSB:`PDT_TB_PS_LSB]; // see R16
    end else if (wr_pend_ff && wr_addr_ff == `PDT_ADDR_PERIOD) begin
      period_ff <= hwdata[12:0];
    end else if (cmp_write) begin
      trigger_compare_value_ff <= hwdata[12:0]; // see R16
    end
  end

  assign cmp_write = wr_pend_ff && wr_addr_ff == `PDT_ADDR_TRIGCMP;

  // Primary counter, cleared while the time base is off
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      primary_counter_ff <= `PDT_CNT_RST;
    end else if (!tb_en_ff || primary_counter_ff == period_ff) begin
      primary_counter_ff <= `PDT_CNT_RST;
    end else begin
      primary_counter_ff <= primary_counter_ff + `PDT_CNT_ONE;
    end
  end

  // Duty compare; values below the minimum never pulse even at count zero
  assign active = (duty_ff == `PDT_DUTY_FULL) || // see R3
                  (duty_ff >= `PDT_DUTY_MIN && // see R1
                   primary_counter_ff <= duty_ff[15:3]); // see R19

  // Independent mode copies the active signal, dead time still applies
  assign low_src = out_indep_ff ? active : ~active; // see R20
  assign dt_on = dead_time_mode_field_ff == pdt_pkg::DT_POSITIVE ||
                 dead_time_mode_field_ff == pdt_pkg::DT_NEGATIVE; // see R7
  assign dt_neg = dead_time_mode_field_ff == pdt_pkg::DT_NEGATIVE; // see R6
  assign coarse_high = pdt_pkg::pdt_coarse(dead_time_ff, dt_on); // see R12
  assign coarse_low = pdt_pkg::pdt_coarse(alternate_dead_time_value_ff, dt_on); // see R10

  // Primary value guards the high output
  pdt_dead_time_unit u_dt_high ( // see R8
    .hclk(hclk),
    .hresetn(hresetn),
    .negative(dt_neg),
    .coarse(coarse_high),
    .src(active),
    .dst(high_dt)
  );

  // Alternate value guards the low output
  pdt_dead_time_unit u_dt_low ( // see R21
    .hclk(hclk),
    .hresetn(hresetn),
    .negative(dt_neg),
    .coarse(coarse_low),
    .src(low_src),
    .dst(low_dt)
  );

  // Registered outputs avoid glitches from the compare logic at the pins
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      high_side_output <= 1'b0;
      low_side_output <= 1'b0;
    end else begin
      high_side_output <= high_dt; // see R4
      low_side_output <= low_dt; // see R5
    end
  end

  // Fine edge bits
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      duty_fine <= 3'h0;
      dt_fine_high <= 1'b0;
      dt_fine_low <= 1'b0;
    end else begin
      duty_fine <= duty_ff[2:0];
      dt_fine_high <= dt_on & dead_time_ff[0]; // see R12
      dt_fine_low <= dt_on & alternate_dead_time_value_ff[0];
    end
  end

  // Trigger has no enable of its own; it ticks only while the time-base enable is set
  pdt_event_trigger u_trig ( // see R17
    .hclk(hclk),
    .hresetn(hresetn),
    .tick(tb_en_ff),
    .counter(primary_counter_ff),
    .compare(trigger_compare_value_ff),
    .postscale(trigger_postscale_field_ff),
    .cmp_write(cmp_write), // see R18
    .trigger(special_event_trigger) // see R15
  );

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  property p_duty_zero;
    duty_ff == `PDT_DUTY_ZERO |-> !active;
  endproperty
  a_duty_zero: assert property (p_duty_zero) else $error("zero duty pulsed"); // see R3

  property p_duty_full;
    duty_ff == `PDT_DUTY_FULL && $stable(duty_ff) |-> active && $past(active);
  endproperty
  a_duty_full: assert property (p_duty_full) else $error("full duty dropped"); // see R3

  property p_duty_min;
    duty_ff < `PDT_DUTY_MIN |-> !active;
  endproperty
  a_duty_min: assert property (p_duty_min) else $error("pulse below minimum duty"); // see R1

  property p_duty_cmp;
    duty_ff >= `PDT_DUTY_MIN && duty_ff != `PDT_DUTY_FULL |->
      active == (primary_counter_ff <= duty_ff[15:3]);
  endproperty
  a_duty_cmp: assert property (p_duty_cmp) else $error("duty compare wrong"); // see R19

  property p_high_delay;
    dead_time_mode_field_ff == pdt_pkg::DT_POSITIVE && coarse_high != `PDT_DT_CNT_ZERO &&
      $rose(active) |=> !high_side_output;
  endproperty
  a_high_delay: assert property (p_high_delay) else $error("high rose early"); // see R9

  property p_low_delay;
    dead_time_mode_field_ff == pdt_pkg::DT_POSITIVE && !out_indep_ff &&
      coarse_low != `PDT_DT_CNT_ZERO && $fell(active) |=> !low_side_output && !high_side_output;
  endproperty
  a_low_delay: assert property (p_low_delay) else $error("low rose early"); // see R4

  property p_neg_overlap;
    dt_neg && !out_indep_ff && coarse_high != `PDT_DT_CNT_ZERO && $fell(active) |=>
      high_side_output && low_side_output;
  endproperty
  a_neg_overlap: assert property (p_neg_overlap) else $error("no overlap"); // see R6

  property p_cmp_clear;
    cmp_write |=> !special_event_trigger;
  endproperty
  a_cmp_clear: assert property (p_cmp_clear) else $error("trigger after compare write"); // see R18

  property p_trig_fire;
    $past(cmp_write) == 1'b0 && tb_en_ff && !cmp_write &&
      primary_counter_ff == trigger_compare_value_ff &&
      trigger_postscale_field_ff == `PDT_PS_RST && $past(trigger_postscale_field_ff) ==
      `PDT_PS_RST |=> special_event_trigger;
  endproperty
  a_trig_fire: assert property (p_trig_fire) else $error("trigger missed"); // see R15

endmodule

// ### sim/pdt_power_stage_model.sv
// Purpose: Far-side model: gate driver pair and ADC start input
// Assumes: Device outputs are levels sampled on hclk
// Notes: Counts on-time, shoot-through and conversion starts per window
module pdt_power_stage_model (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Window control
  input wire logic clr,
  // Device outputs
  input wire logic gate_high,
  input wire logic gate_low,
  input wire logic adc_start,
  // Counts
  output logic [15:0] high_cnt_ff,
  output logic [15:0] low_cnt_ff,
  output logic [15:0] shoot_cnt_ff,
  output logic [15:0] conv_cnt_ff
);
  // Shoot-through is counted, not refused, so negative dead time can be measured
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn || clr) begin
      high_cnt_ff <= 16'h0000;
      low_cnt_ff <= 16'h0000;
      shoot_cnt_ff <= 16'h0000;
    end else begin
      high_cnt_ff <= high_cnt_ff + {15'h0000, gate_high === 1'b1};
      low_cnt_ff <= low_cnt_ff + {15'h0000, gate_low === 1'b1};
      shoot_cnt_ff <= shoot_cnt_ff + {15'h0000, (gate_high & gate_low) === 1'b1};
    end
  end
  // ADC starts a conversion on every sampled pulse
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn || clr)
      conv_cnt_ff <= 16'h0000;
    else
      conv_cnt_ff <= conv_cnt_ff + {15'h0000, adc_start === 1'b1};
  end
endmodule

// ### sim/tb_top.sv
// Purpose: Self-checking bench for the PWM dead-time block
// Assumes: Zero-wait slave, hready fed back from hreadyout
// Notes: Counts span whole PWM periods, so phase does not matter, except in the final 48-cycle trigger check
`include "pdt_defines.svh"
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, clr;
  logic hso, lso, dfh, dfl, trig;
  logic [1:0] htrans;
  logic [2:0] hsize, dfine;
  logic [31:0] haddr, hwdata, hrdata;
  logic [15:0] hc, lc, sc, tc;
  int error_cnt, cmp_count, cyc;
  logic [2:0] ctl [9] = '{3'h2, 3'h3, 3'h2, 3'h2, 3'h2, 3'h2, 3'h0, 3'h1, 3'h4};
  logic [15:0] dty [9] = '{16'h0040, 16'h0040, 16'h0007, 16'h0008, 16'h0000,
                           16'hffff, 16'h0045, 16'h0045, 16'h0045};
  int ehi [9] = '{18, 18, 0, 4, 0, 64, 12, 24, 12};
  int elo [9] = '{46, 46, 64, 60, 64, 0, 36, 56, 8};
  int eov [9] = '{0, 0, 0, 0, 0, 0, 0, 16, 8};
  logic [3:0] pss [3] = '{4'h0, 4'h2, 4'hf};

  assign hready = hreadyout;

  pdt_top dut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .high_side_output(hso), .low_side_output(lso), .duty_fine(dfine),
    .dt_fine_high(dfh), .dt_fine_low(dfl), .special_event_trigger(trig)
  );

  pdt_power_stage_model far (
    .hclk(hclk), .hresetn(hresetn), .clr(clr), .gate_high(hso), .gate_low(lso),
    .adc_start(trig), .high_cnt_ff(hc), .low_cnt_ff(lc), .shoot_cnt_ff(sc),
    .conv_cnt_ff(tc)
  );

  initial begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end

  // Whole run needs about 2700 cycles
  always @(posedge hclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      error_cnt++;
      test_done();
    end
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic addr_phase(input logic [7:0] a, input logic w);
    hsel <= 1'b1;
    haddr <= {24'h000000, a};
    htrans <= 2'b10;
    hwrite <= w;
    do @(posedge hclk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    addr_phase(a, 1'b1);
    hwdata <= d;
    do @(posedge hclk); while (hready !== 1'b1);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    addr_phase(a, 1'b0);
    do @(posedge hclk); while (hready !== 1'b1);
    chk(hrdata, exp);
    chk({31'h0, hresp}, 32'h0);
  endtask

  // Counting window of n cycles, opened after a settle time
  task automatic meas(input int settle, input int n);
    repeat (settle) @(posedge hclk);
    clr <= 1'b1;
    @(posedge hclk);
    clr <= 1'b0;
    repeat (n) @(posedge hclk);
    #1;
  endtask

  task automatic test_done();
    $display("counts: %0d compares, %0d mismatches", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    clr = 1'b0;
    error_cnt = 0;
    cmp_count = 0;
    cyc = 0;
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rd(`PDT_ADDR_DUTY, {16'h0000, `PDT_DUTY_RST});
    rd(`PDT_ADDR_PERIOD, {19'h00000, `PDT_PERIOD_RST});
    rd(`PDT_ADDR_CTRL, 32'h0);
    rd(`PDT_ADDR_STATUS, 32'h00000002);
    wr(`PDT_ADDR_DTIME, 32'hffffffff);
    wr(8'h20, 32'hffffffff);
    rd(`PDT_ADDR_DTIME, 32'h00000fff);
    rd(8'h20, 32'h0);
    $display("test registers done");
    // Period of 32 cycles; dead times 7 and 11 count 3 and 5 coarse cycles
    wr(`PDT_ADDR_PERIOD, 32'h0000001f);
    wr(`PDT_ADDR_DTIME, 32'h00000007);
    wr(`PDT_ADDR_ALTDT, 32'h0000000b);
    wr(`PDT_ADDR_TBCTL, 32'h00008000);
    for (int i = 0; i < 9; i++) begin
      wr(`PDT_ADDR_CTRL, {29'h0, ctl[i]});
      wr(`PDT_ADDR_DUTY, {16'h0000, dty[i]});
      meas(64, 64);
      chk(hc, ehi[i]);
      chk(lc, elo[i]);
      chk(sc, eov[i]);
      chk(dfine, dty[i][2:0]);
      chk(dfh, ctl[i][1:0] < 2'h2);
      chk(dfl, ctl[i][1:0] < 2'h2);
    end
    $display("test pwm done");
    for (int i = 0; i < 3; i++) begin
      wr(`PDT_ADDR_TBCTL, {16'h0000, 12'h800, pss[i]});
      wr(`PDT_ADDR_TRIGCMP, 32'h00000005);
      meas(0, 64 * (pss[i] + 1));
      chk(tc, 2);
    end
    // One hit lands before the second compare write, which must discard it
    wr(`PDT_ADDR_TBCTL, 32'h00008001);
    wr(`PDT_ADDR_TRIGCMP, 32'h00000005);
    repeat (14) @(posedge hclk);
    wr(`PDT_ADDR_TRIGCMP, 32'h00000005);
    meas(0, 48);
    chk(tc, 0);
    meas(0, 64);
    chk(tc, 1);
    $display("test trigger done");
    test_done();
  end
endmodule
